// File: logic/fdm_pkg.sv
// Constants and types shared by the nonvolatile data memory sequencer
package fdm_pkg;
    localparam int CLK_MHZ = 200;
    localparam int MC_CLKS = 1;
    localparam int T_PG_WRITE_US = 380;
    localparam int T_ERASE_US = 2000;
    localparam int T_BYTE_WRITE_US = 200;
    localparam int T_PM_PG_WRITE_US = 15000;
    localparam int N_PG_RD_MC = 25;
    localparam int N_BYTE_RD_MC = 10;
    localparam int CYC_PG_RD = N_PG_RD_MC * MC_CLKS;
    localparam int CYC_BYTE_RD = N_BYTE_RD_MC * MC_CLKS;
    localparam int CYC_PG_WRITE = T_PG_WRITE_US * CLK_MHZ;
    localparam int CYC_ERASE = T_ERASE_US * CLK_MHZ;
    localparam int CYC_BYTE_WRITE = T_BYTE_WRITE_US * CLK_MHZ;
    localparam int CYC_PM_PG_WRITE = T_PM_PG_WRITE_US * CLK_MHZ;
    localparam int TMR_W = 22;
    localparam int DM_BYTES = 4096;
    localparam int PM_BYTES = 57344;
    localparam int PAGE_BYTES = 4;
    localparam int PM_WR_BYTES = 256;
    localparam int PM_ER_BYTES = 64;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [7:0] VFY_FAIL = 8'h01;
    localparam logic [5:0] REG_ADDR_HIGH = 6'h00;
    localparam logic [5:0] REG_ADDR_LOW = 6'h04;
    localparam logic [5:0] REG_DATA1 = 6'h08;
    localparam logic [5:0] REG_DATA2 = 6'h0c;
    localparam logic [5:0] REG_DATA3 = 6'h10;
    localparam logic [5:0] REG_DATA4 = 6'h14;
    localparam logic [5:0] REG_CMD = 6'h18;
    localparam logic [5:0] REG_STATUS = 6'h1c;
    localparam logic [7:0] CMD_PAGE_READ = 8'h01;
    localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
    localparam logic [7:0] CMD_PAGE_VERIFY = 8'h04;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h05;
    localparam logic [7:0] CMD_FULL_ERASE = 8'h06;
    localparam logic [7:0] CMD_BYTE_READ = 8'h81;
    localparam logic [7:0] CMD_BYTE_WRITE = 8'h82;
    localparam logic [7:0] CMD_TO_PROGRAM = 8'hf0;
    localparam logic [7:0] CMD_TO_DATA = 8'h0f;
    typedef enum logic [3:0] {
        OP_NONE, OP_RD_PG, OP_WR_PG, OP_VFY, OP_ER_PG, OP_ER_ALL, OP_RD_BYTE,
        OP_WR_BYTE, OP_PM_WR_PG, OP_PM_ER_PG, OP_PM_ER_ALL, OP_PM_WR_BYTE
    } fdm_op_type;
    typedef struct packed {
        logic read;
        logic write;
        logic [5:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } fdm_avs_req_type;
endpackage

// File: logic/fdm_timer.sv
// Down-counter that times one memory operation
`timescale 1ns/1ps
`default_nettype none
module fdm_timer import fdm_pkg::*; (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [TMR_W-1:0] count,
    output logic done
);
    logic [TMR_W-1:0] cnt_reg, cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = count;
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign done = (cnt_reg == '0) && !load;
endmodule
`default_nettype wire

// File: logic/fdm_mem.sv
// Byte array with erase-to-ones and bit-clearing program
`timescale 1ns/1ps
`default_nettype none
module fdm_mem import fdm_pkg::*; #(
    parameter int DEPTH = DM_BYTES,
    parameter int AW = 12
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [AW-1:0] addr,
    input wire logic prog,
    input wire logic erase,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [DEPTH];
    logic in_range;

    // Shipped erased
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = ERASED;
        end
    end

    assign in_range = 32'(addr) < DEPTH;
    assign rdata = in_range ? mem[addr] : ERASED;

    always_ff @(posedge mclk) begin
        if (in_range && erase) begin
            mem[addr] <= ERASED;
        end else if (in_range && prog) begin
            mem[addr] <= mem[addr] & wdata;
        end
    end

    property p_prog_clears;
        @(posedge mclk) disable iff (!rst_n)
        (prog && !erase && in_range) |=> (mem[$past(addr)] & ~$past(rdata)) == 8'h00;
    endproperty
    a_prog_clears: assert property (p_prog_clears) else $error("program set a bit");
endmodule
`default_nettype wire

// File: logic/fdm_sequencer.sv
// Command sequencer for the nonvolatile data memory behind an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
//----------------------------------------------------------------
//----------------------------------------------------------------
module fdm_sequencer import fdm_pkg::*; #(
    parameter int P_CYC_PG_WRITE = CYC_PG_WRITE,
    parameter int P_CYC_ERASE = CYC_ERASE,
    parameter int P_CYC_BYTE_WRITE = CYC_BYTE_WRITE,
    parameter int P_CYC_PM_PG_WRITE = CYC_PM_PG_WRITE
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire fdm_avs_req_type avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [7:0] xram_addr,
    input wire logic [7:0] xram_rdata,
    output logic core_stall,
    output logic irq_hold
);
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DONE} fdm_state_type;

    //------------------------------------------------------------
    // Reset release
    //------------------------------------------------------------
    logic rst_meta_reg, rst_n;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    //------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------
    fdm_state_type st_reg, st_next;
    fdm_op_type op_reg, op_next, dec_op;
    logic [7:0] addr_high_reg, addr_high_next, addr_low_reg, addr_low_next;
    logic [7:0] hold_reg [PAGE_BYTES];
    logic [7:0] hold_next [PAGE_BYTES];
    logic [7:0] cmd_reg, cmd_next;
    logic pm_mode_reg, pm_mode_next, miss_reg, miss_next;
    logic [15:0] base_reg, base_next, last_reg, last_next, idx_reg, idx_next;
    logic [15:0] full_addr, dec_base, dec_last, mem_addr;
    logic [TMR_W-1:0] dec_cyc;
    logic rd_ack_reg, rd_ack_next;
    logic [31:0] readdata_reg, readdata_next;
    logic wr_cmd, bus_wr, act, tmr_load, tmr_done;
    logic dm_prog, dm_erase, pm_prog, pm_erase;
    logic [7:0] dm_wdata, pm_wdata, dm_rdata;

    assign full_addr = {addr_high_reg, addr_low_reg};
    assign wr_cmd = avs_req.write && avs_req.byteenable[0] && avs_req.address == REG_CMD;

    //------------------------------------------------------------
    // Command decode
    //------------------------------------------------------------
    always_comb begin
        dec_op = OP_NONE;
        dec_base = '0;
        dec_last = '0;
        dec_cyc = '0;
        if (!pm_mode_reg) begin
            case (avs_req.writedata[7:0])
                CMD_PAGE_READ: begin
                    dec_op = OP_RD_PG;
                    dec_cyc = TMR_W'(CYC_PG_RD);
                end
                CMD_PAGE_WRITE: begin
                    dec_op = OP_WR_PG;
                    dec_cyc = TMR_W'(P_CYC_PG_WRITE);
                end
                CMD_PAGE_VERIFY: begin
                    dec_op = OP_VFY;
                    dec_cyc = TMR_W'(CYC_PG_RD);
                end
                CMD_PAGE_ERASE: begin
                    dec_op = OP_ER_PG;
                    dec_cyc = TMR_W'(P_CYC_ERASE);
                end
                CMD_FULL_ERASE: begin
                    dec_op = OP_ER_ALL;
                    dec_last = 16'(DM_BYTES - 1);
                    dec_cyc = TMR_W'(P_CYC_ERASE);
                end
                CMD_BYTE_READ: begin
                    dec_op = OP_RD_BYTE;
                    dec_cyc = TMR_W'(CYC_BYTE_RD);
                end
                CMD_BYTE_WRITE: begin
                    dec_op = OP_WR_BYTE;
                    dec_cyc = TMR_W'(P_CYC_BYTE_WRITE);
                end
                default: begin
                    dec_op = OP_NONE;
                end
            endcase
            if (dec_op inside {OP_RD_PG, OP_WR_PG, OP_VFY, OP_ER_PG}) begin
                // Page ops take the page index; erase spans the whole page
                dec_base = {4'h0, full_addr[9:0], 2'b00};
                dec_last = 16'(PAGE_BYTES - 1);
            end else if (dec_op inside {OP_RD_BYTE, OP_WR_BYTE}) begin
                dec_base = {4'h0, full_addr[11:0]};
            end
        end else begin
            case (avs_req.writedata[7:0])
                CMD_PAGE_WRITE: begin
                    dec_op = OP_PM_WR_PG;
                    dec_base = {full_addr[7:0], 8'h00};
                    dec_last = 16'(PM_WR_BYTES - 1);
                    dec_cyc = TMR_W'(P_CYC_PM_PG_WRITE);
                end
                CMD_PAGE_ERASE: begin
                    dec_op = OP_PM_ER_PG;
                    dec_base = {full_addr[15:6], 6'h00};
                    dec_last = 16'(PM_ER_BYTES - 1);
                    dec_cyc = TMR_W'(P_CYC_ERASE);
                end
                CMD_FULL_ERASE: begin
                    dec_op = OP_PM_ER_ALL;
                    dec_last = 16'(PM_BYTES - 1);
                    dec_cyc = TMR_W'(P_CYC_ERASE);
                end
                CMD_BYTE_WRITE: begin
                    dec_op = OP_PM_WR_BYTE;
                    dec_base = full_addr;
                    dec_cyc = TMR_W'(P_CYC_BYTE_WRITE);
                end
                default: begin
                    dec_op = OP_NONE;
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // Bus handshake
    //------------------------------------------------------------
    // A command write that decodes to an operation is held off until the operation ends; that is the stall
    assign avs_waitrequest = (avs_req.read && !rd_ack_reg)
        || (wr_cmd && st_reg != ST_DONE && (st_reg != ST_IDLE || dec_op != OP_NONE));
    assign bus_wr = avs_req.write && avs_req.byteenable[0] && !avs_waitrequest;
    assign core_stall = st_reg != ST_IDLE && st_reg != ST_DONE;
    assign irq_hold = core_stall;
    assign avs_readdata = readdata_reg;

    always_comb begin
        rd_ack_next = avs_req.read && !rd_ack_reg;
        readdata_next = readdata_reg;
        if (avs_req.read && !rd_ack_reg) begin
            case (avs_req.address)
                REG_ADDR_HIGH: readdata_next = {24'h0, addr_high_reg};
                REG_ADDR_LOW: readdata_next = {24'h0, addr_low_reg};
                REG_DATA1: readdata_next = {24'h0, hold_reg[0]};
                REG_DATA2: readdata_next = {24'h0, hold_reg[1]};
                REG_DATA3: readdata_next = {24'h0, hold_reg[2]};
                REG_DATA4: readdata_next = {24'h0, hold_reg[3]};
                REG_CMD: readdata_next = {24'h0, cmd_reg};
                REG_STATUS: readdata_next = {30'h0, pm_mode_reg, core_stall};
                default: readdata_next = 32'h0;
            endcase
        end
    end

    //------------------------------------------------------------
    // Sequencer
    //------------------------------------------------------------
    // Bytes are walked one per clock while the timer runs in parallel
    assign act = st_reg == ST_BUSY && idx_reg <= last_reg;
    assign mem_addr = base_reg + idx_reg;
    assign xram_addr = idx_reg[7:0];
    assign dm_prog = act && (op_reg == OP_WR_PG || op_reg == OP_WR_BYTE);
    assign dm_erase = act && (op_reg == OP_ER_PG || op_reg == OP_ER_ALL);
    assign dm_wdata = (op_reg == OP_WR_BYTE) ? hold_reg[0] : hold_reg[idx_reg[1:0]];
    assign pm_prog = act && (op_reg == OP_PM_WR_PG || op_reg == OP_PM_WR_BYTE);
    assign pm_erase = act && (op_reg == OP_PM_ER_PG || op_reg == OP_PM_ER_ALL);
    assign pm_wdata = (op_reg == OP_PM_WR_PG) ? xram_rdata : hold_reg[0];

    always_comb begin
        st_next = st_reg;
        op_next = op_reg;
        base_next = base_reg;
        last_next = last_reg;
        idx_next = idx_reg;
        miss_next = miss_reg;
        tmr_load = 1'b0;
        case (st_reg)
            ST_IDLE: begin
                if (wr_cmd && dec_op != OP_NONE) begin
                    st_next = ST_BUSY;
                    op_next = dec_op;
                    base_next = dec_base;
                    last_next = dec_last;
                    idx_next = '0;
                    miss_next = 1'b0;
                    tmr_load = 1'b1;
                end
            end
            ST_BUSY: begin
                if (act) begin
                    idx_next = idx_reg + 16'h0001;
                end else if (tmr_done) begin
                    st_next = ST_DONE;
                end
                if (act && op_reg == OP_VFY && dm_rdata != hold_reg[idx_reg[1:0]]) begin
                    miss_next = 1'b1;
                end
            end
            ST_DONE: st_next = ST_IDLE;
            default: st_next = ST_IDLE;
        endcase
    end

    //------------------------------------------------------------
    // Software registers
    //------------------------------------------------------------
    always_comb begin
        addr_high_next = addr_high_reg;
        addr_low_next = addr_low_reg;
        hold_next = hold_reg;
        cmd_next = cmd_reg;
        pm_mode_next = pm_mode_reg;
        if (bus_wr) begin
            case (avs_req.address)
                REG_ADDR_HIGH: addr_high_next = avs_req.writedata[7:0];
                REG_ADDR_LOW: addr_low_next = avs_req.writedata[7:0];
                REG_DATA1: hold_next[0] = avs_req.writedata[7:0];
                REG_DATA2: hold_next[1] = avs_req.writedata[7:0];
                REG_DATA3: hold_next[2] = avs_req.writedata[7:0];
                REG_DATA4: hold_next[3] = avs_req.writedata[7:0];
                REG_CMD: cmd_next = avs_req.writedata[7:0];
                default: cmd_next = cmd_reg;
            endcase
            if (avs_req.address == REG_CMD && avs_req.writedata[7:0] == CMD_TO_PROGRAM) begin
                pm_mode_next = 1'b1;
            end else if (avs_req.address == REG_CMD
                    && avs_req.writedata[7:0] == CMD_TO_DATA) begin
                pm_mode_next = 1'b0;
            end
        end
        if (st_reg == ST_DONE && op_reg == OP_VFY) begin
            cmd_next = miss_reg ? VFY_FAIL : 8'h00;
        end
        if (act && op_reg == OP_RD_PG) begin
            hold_next[idx_reg[1:0]] = dm_rdata;
        end
        if (act && op_reg == OP_RD_BYTE) begin
            hold_next[0] = dm_rdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= ST_IDLE;
            op_reg <= OP_NONE;
            base_reg <= '0;
            last_reg <= '0;
            idx_reg <= '0;
            miss_reg <= 1'b0;
            rd_ack_reg <= 1'b0;
            readdata_reg <= '0;
            addr_high_reg <= '0;
            addr_low_reg <= '0;
            hold_reg <= '{default: 8'h00};
            cmd_reg <= '0;
            pm_mode_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            op_reg <= op_next;
            base_reg <= base_next;
            last_reg <= last_next;
            idx_reg <= idx_next;
            miss_reg <= miss_next;
            rd_ack_reg <= rd_ack_next;
            readdata_reg <= readdata_next;
            addr_high_reg <= addr_high_next;
            addr_low_reg <= addr_low_next;
            hold_reg <= hold_next;
            cmd_reg <= cmd_next;
            pm_mode_reg <= pm_mode_next;
        end
    end

    //------------------------------------------------------------
    // Submodules
    //------------------------------------------------------------
    // The bus master is stalled via waitrequest and the core via core_stall; this timer keeps running on mclk
    fdm_timer u_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(tmr_load),
        .count(dec_cyc),
        .done(tmr_done)
    );

    fdm_mem #(.DEPTH(DM_BYTES), .AW(12)) u_data_mem (
        .mclk(mclk),
        .rst_n(rst_n),
        .addr(mem_addr[11:0]),
        .prog(dm_prog),
        .erase(dm_erase),
        .wdata(dm_wdata),
        .rdata(dm_rdata)
    );

    fdm_mem #(.DEPTH(PM_BYTES), .AW(16)) u_prog_mem (
        .mclk(mclk),
        .rst_n(rst_n),
        .addr(mem_addr),
        .prog(pm_prog),
        .erase(pm_erase),
        .wdata(pm_wdata),
        .rdata()
    );

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic [TMR_W-1:0] busy_cnt_reg, len_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_reg <= '0;
            len_reg <= '0;
        end else if (tmr_load) begin
            busy_cnt_reg <= '0;
            len_reg <= dec_cyc;
        end else if (st_reg == ST_BUSY) begin
            busy_cnt_reg <= busy_cnt_reg + 1'b1;
        end
    end

    property p_start;
        st_reg == ST_IDLE && wr_cmd && dec_op != OP_NONE |-> avs_waitrequest ##1 st_reg == ST_BUSY;
    endproperty
    a_start: assert property (p_start) else $error("command did not start");
    property p_stall;
        st_reg == ST_BUSY && wr_cmd |-> avs_waitrequest && core_stall && irq_hold;
    endproperty
    a_stall: assert property (p_stall) else $error("core not stalled");
    property p_irq;
        irq_hold && !tmr_done |=> irq_hold;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt hold dropped early");
    property p_duration;
        st_reg == ST_DONE |-> busy_cnt_reg >= len_reg;
    endproperty
    a_duration: assert property (p_duration) else $error("operation ended early");
    property p_page_read;
        act && op_reg == OP_RD_PG |=> hold_reg[$past(idx_reg[1:0])] == $past(dm_rdata);
    endproperty
    a_page_read: assert property (p_page_read) else $error("page read lost a byte");
    property p_erase_page;
        st_reg == ST_BUSY && op_reg == OP_ER_PG |-> last_reg == 16'h0003 && base_reg[1:0] == 2'b00;
    endproperty
    a_erase_page: assert property (p_erase_page) else $error("partial page erase");
    property p_verify;
        st_reg == ST_DONE && op_reg == OP_VFY |=> (cmd_reg == 8'h00) == !$past(miss_reg);
    endproperty
    a_verify: assert property (p_verify) else $error("verify result wrong");
    property p_mode;
        bus_wr && avs_req.address == REG_CMD && avs_req.writedata[7:0] == CMD_TO_PROGRAM
            |=> pm_mode_reg;
    endproperty
    a_mode: assert property (p_mode) else $error("program mode not entered");
    property p_unknown;
        st_reg == ST_IDLE && wr_cmd && dec_op == OP_NONE |-> !avs_waitrequest ##1 st_reg == ST_IDLE;
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown code stalled");

    c_vfy_pass: cover property (st_reg == ST_DONE && op_reg == OP_VFY && !miss_reg);
    c_vfy_fail: cover property (st_reg == ST_DONE && op_reg == OP_VFY && miss_reg);
    c_full_erase: cover property (st_reg == ST_DONE && op_reg == OP_ER_ALL);
    c_pm_write: cover property (st_reg == ST_DONE && op_reg == OP_PM_WR_PG);
endmodule
`default_nettype wire

// File: sim/fdm_xram_model.sv
// Internal data RAM seen by the sequencer during program-memory page write
`timescale 1ns/1ps
`default_nettype none
module fdm_xram_model (
    input wire logic [7:0] xram_addr,
    output logic [7:0] xram_rdata
);
    // Asynchronous read; the complement differs from byte to byte
    assign xram_rdata = ~xram_addr;
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the data memory command sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin failures++; \
    $display("Error %s expected %h seen %h", nm, e, s); end end
module tb import fdm_pkg::*;;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    fdm_avs_req_type req = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, core_stall, irq_hold;
    logic [7:0] xram_addr, xram_rdata, rd;
    int cyc, stl, bad_hold, failures, n_checks;
    always #2.5 mclk = ~mclk;
    fdm_sequencer #(.P_CYC_PG_WRITE(20), .P_CYC_ERASE(30), .P_CYC_BYTE_WRITE(10),
        .P_CYC_PM_PG_WRITE(40)) i_dut (.mclk(mclk), .nrst(nrst), .avs_req(req),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .xram_addr(xram_addr), .xram_rdata(xram_rdata), .core_stall(core_stall),
        .irq_hold(irq_hold));
    fdm_xram_model i_xram (.xram_addr(xram_addr), .xram_rdata(xram_rdata));
    //--------------------------------
    // Bus access
    //--------------------------------
    // Request stands until waitrequest is seen low at a rising edge
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
        logic wt;
        cyc = 0;
        @(posedge mclk);
        req <= '{read: !w, write: w, address: a, writedata: {24'h0, d}, byteenable: 4'hf};
        do begin
            @(posedge mclk);
            wt = avs_waitrequest;
            rd = avs_readdata[7:0];
            if (irq_hold !== core_stall) bad_hold++;
            if (core_stall === 1'b1) stl++;
            cyc++;
        end while (wt !== 1'b0 && cyc < 9000);
        // A stuck stall is a failure, not a silent give-up
        if (wt !== 1'b0) failures++;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask
    task automatic ld(input logic [31:0] v);
        for (int i = 0; i < 4; i++) acc(1'b1, REG_DATA1 + 6'(4 * i), v[8*i+:8]);
    endtask
    task automatic cmd(input logic [7:0] c);
        stl = 0;
        acc(1'b1, REG_CMD, c);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    //--------------------------------
    // Tests
    //--------------------------------
    initial begin
        #(60000 * 5);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        acc(1'b1, REG_ADDR_HIGH, 8'h01);
        acc(1'b1, REG_ADDR_LOW, 8'h02);
        cmd(CMD_PAGE_READ);
        acc(1'b0, REG_DATA2, 8'h00);
        `CHK("fresh byte", 8'hff, rd)
        ld(32'h4433f311);
        cmd(CMD_PAGE_ERASE);
        `CHK("erase stall", 1'b1, stl >= 30)
        cmd(CMD_PAGE_WRITE);
        `CHK("write stall", 1'b1, stl >= 20)
        cmd(CMD_PAGE_VERIFY);
        acc(1'b0, REG_CMD, 8'h00);
        `CHK("verify pass", 8'h00, rd)
        ld(32'h0);
        cmd(CMD_PAGE_READ);
        acc(1'b0, REG_DATA2, 8'h00);
        `CHK("page byte2", 8'hf3, rd)
        acc(1'b0, REG_DATA4, 8'h00);
        `CHK("page byte4", 8'h44, rd)
        $display("page program test done");
        ld(32'h440ff311);
        cmd(CMD_PAGE_WRITE);
        cmd(CMD_PAGE_VERIFY);
        acc(1'b0, REG_CMD, 8'h00);
        `CHK("verify miss", VFY_FAIL, rd)
        cmd(CMD_PAGE_READ);
        acc(1'b0, REG_DATA3, 8'h00);
        `CHK("no erase", 8'h03, rd)
        $display("overwrite test done");
        acc(1'b1, REG_ADDR_HIGH, 8'h00);
        acc(1'b1, REG_ADDR_LOW, 8'h10);
        acc(1'b1, REG_DATA1, 8'h5a);
        cmd(CMD_BYTE_WRITE);
        acc(1'b1, REG_DATA1, 8'h00);
        cmd(CMD_BYTE_READ);
        acc(1'b0, REG_DATA1, 8'h00);
        `CHK("byte rw", 8'h5a, rd)
        cmd(8'h03);
        `CHK("reserved cyc", 1, cyc)
        `CHK("reserved stall", 0, stl)
        cmd(CMD_TO_PROGRAM);
        acc(1'b0, REG_STATUS, 8'h00);
        `CHK("pm mode", 8'h02, rd)
        cmd(CMD_PAGE_READ);
        `CHK("pm read none", 1, cyc)
        cmd(CMD_PAGE_ERASE);
        `CHK("pm erase stall", 1'b1, stl >= 64)
        cmd(CMD_PAGE_WRITE);
        `CHK("pm write stall", 1'b1, stl >= 256)
        cmd(CMD_TO_DATA);
        acc(1'b0, REG_STATUS, 8'h00);
        `CHK("dm mode", 8'h00, rd)
        acc(1'b1, REG_DATA1, 8'h00);
        cmd(CMD_BYTE_READ);
        acc(1'b0, REG_DATA1, 8'h00);
        `CHK("dm kept", 8'h5a, rd)
        $display("command code test done");
        cmd(CMD_FULL_ERASE);
        `CHK("erase all stall", 1'b1, stl >= 4096)
        cmd(CMD_BYTE_READ);
        acc(1'b0, REG_DATA1, 8'h00);
        `CHK("erased byte", 8'hff, rd)
        acc(1'b1, REG_ADDR_HIGH, 8'h01);
        acc(1'b1, REG_ADDR_LOW, 8'h02);
        cmd(CMD_PAGE_READ);
        acc(1'b0, REG_DATA2, 8'h00);
        `CHK("erased page", 8'hff, rd)
        `CHK("irq hold", 0, bad_hold)
        $display("full erase test done");
        wrap_up();
    end
endmodule
`default_nettype wire
